// File: dtcd_core.sv
// Purpose: Output sample clock timing engine, trigger handling, line states and change detection
// Assumes: Inputs other than dio_i and pfi_i synchronous to clk_i; timebase ticks arrive as one-cycle strobes
// Notes:   Registers sit on a classic Wishbone slave, one cycle to answer
// Function
// RULE1: Sample clock divides a timebase chosen from 100M, 20M, 100k or external; 100M default.
// RULE2: The timebase itself is never routable to an output line.
// RULE3: Generation starts on the start trigger, or on software start without one.
// RULE4: Retriggerable mode produces the full sample set on every start trigger.
// RULE5: Start triggers are ignored during a burst; afterwards the engine waits again.
// RULE6: Start trigger edge is selectable rising or falling; only that edge starts.
// RULE7: An exported start trigger is an active-high pulse.
// RULE8: While pause is active no output sample clocks are produced.
// RULE9: Pause never cuts a sample in progress; it acts from the next sample.
// RULE10: With onboard timebase, generation resumes immediately when pause deasserts.
// RULE11: With other sources, resume needs pause deasserted then a new clock edge.
// RULE12: Pause is level sensitive with selectable high or low polarity.
// RULE13: After reset every pfi and dio line is an undriven input.
// RULE14: Each dio line takes a programmed state: input, drive 0 or drive 1.
// RULE15: Each input line enables rising, falling or both edges for change detection.
// RULE16: Every input is synchronised before it reaches its change detector.
// RULE17: Change event is the OR of all enabled edge detectors.
// RULE18: Changes within one 50 ns window form a single change event.
// RULE19: Change event can clock samples, drive trigger lines and flag an interrupt.
// RULE20: Change event can start digital output, analog output or counter generations.
// RULE21: A sample clock with an empty output buffer flags an underflow.
// RULE22: A programmable delay, default two ticks, precedes the first sample clock.
// RULE23: A programmable sample count ends each finite generation.
// RULE24: Host sets timebase, divisor, sources, edges and polarity while idle.
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module dtcd_core
   import dtcd_pkg::*;
(
   input  wire logic               clk_i,                 // System clock, 50 MHz
   input  wire logic               rst_i,                 // Synchronous reset, active high
   input  wire logic               ce_i,                  // Clock enable, freezes all state when low
   input  wire logic               wb_cyc_i,              // Wishbone cycle
   input  wire logic               wb_stb_i,              // Wishbone strobe
   input  wire logic               wb_we_i,               // Wishbone write enable
   input  wire logic [7:0]         wb_adr_i,              // Wishbone byte address
   input  wire logic [3:0]         wb_sel_i,              // Wishbone byte lanes
   input  wire logic [31:0]        wb_dat_i,              // Wishbone write data
   output logic      [31:0]        wb_dat_o,              // Wishbone read data
   output logic                    wb_ack_o,              // Wishbone acknowledge
   input  wire logic               tick_100mhz_i,         // 100 MHz timebase tick strobe
   input  wire logic               tick_20mhz_i,          // 20 MHz timebase tick strobe
   input  wire logic               tick_100khz_i,         // 100 kHz timebase tick strobe
   input  wire logic               input_start_trigger_i, // Neighbour start trigger level
   input  wire logic               input_pause_trigger_i, // Neighbour pause trigger level
   input  wire logic               out_buf_empty_i,       // Output sample buffer empty
   input  wire logic [NUM_DIO-1:0] dio_i,                 // Digital io line levels
   output logic      [NUM_DIO-1:0] dio_o,                 // Digital io drive values
   output logic      [NUM_DIO-1:0] dio_oe_o,              // Digital io drive enables
   input  wire logic [NUM_PFI-1:0] pfi_i,                 // Programmable function line levels
   output logic      [NUM_PFI-1:0] pfi_o,                 // Programmable function drive values
   output logic      [NUM_PFI-1:0] pfi_oe_o,              // Programmable function drive enables
   output logic                    star_o,                // Star trigger out line value
   output logic                    star_oe_o,             // Star trigger out line enable
   output logic                    output_sample_clock_o, // Output sample clock pulse
   output logic                    output_start_trigger_o,// Accepted start trigger pulse
   output logic                    cd_event_o,            // Change detection event pulse
   output logic                    cd_irq_o               // Change seen flag, level
);

   // Byte-lane merge for register writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   // Edge detect with selectable direction
   function automatic logic edge_hit(input logic cur, input logic prev, input logic fall);
      return fall ? (prev & ~cur) : (cur & ~prev);
   endfunction : edge_hit

   dtcd_ctrl_t        ctrl;
   dtcd_state_t       state;
   logic [31:0]       divisor;
   logic [31:0]       delay;
   logic [31:0]       count;
   logic [NUM_CD-1:0] cd_rise;
   logic [NUM_CD-1:0] cd_fall;
   logic [15:0]       pu_dir;
   logic [15:0]       pu_val;
   logic [17:0]       route;
   logic              underflow;
   logic [NUM_CD-1:0] sync1;
   logic [NUM_CD-1:0] sync2;
   logic [NUM_CD-1:0] prev;
   logic [NUM_CD-1:0] det;
   logic [2:0]        win_cnt;
   logic              trig_prev;
   logic              ext_prev;
   logic [31:0]       div_cnt;
   logic [31:0]       dly_cnt;
   logic [31:0]       smp_cnt;
   logic              pend;
   logic              bus_req;
   logic              wr_fire;
   logic              wr_ctrl;
   logic [31:0]       wr_ctrl_v;
   logic [NUM_PFI-1:0] pfi_s;
   logic              trig_lvl;
   logic              trig_hit;
   logic              pause_lvl;
   logic              pause_act;
   logic              ext_edge;
   logic              tb_tick;
   logic              onboard;
   logic              div_end;
   logic              raw_tick;
   logic              emit;
   logic              last_smp;
   logic              start_go;
   logic              cd_event_w;
   logic [31:0]       rd_v;

   // Bus decode; writes land on the ack edge
   assign bus_req   = wb_cyc_i & wb_stb_i;
   assign wr_fire   = bus_req & wb_we_i & wb_ack_o;
   assign wr_ctrl   = wr_fire & (wb_adr_i == OFF_CTRL);
   assign wr_ctrl_v = lane_merge(ctrl, wb_dat_i, wb_sel_i);

   // Two-flop synchronisers, previous values, trigger edge history
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= '0;
         sync2 <= '0;
         prev  <= '0;
         trig_prev <= 1'b0;
         ext_prev <= 1'b0;
      end else if (ce_i) begin
         sync1 <= {pfi_i, dio_i}; // RULE16
         sync2 <= sync1; // RULE16
         prev  <= sync2;
         trig_prev <= trig_lvl;
         ext_prev <= pfi_s[ctrl.tb_line];
      end
   end

   assign pfi_s = sync2[NUM_CD-1:NUM_DIO];

   // Per-line rising and falling detectors
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CD; gi++) begin : g_cd
         assign det[gi] = (cd_rise[gi] & sync2[gi] & ~prev[gi])
                        | (cd_fall[gi] & ~sync2[gi] & prev[gi]);   // RULE15
      end
   endgenerate

   assign cd_event_w = (|det) & (win_cnt == 3'h0); // RULE17 RULE18

   // Merge window folds changes into one event
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_cnt    <= 3'h0;
         cd_event_o <= 1'b0;
      end else if (ce_i) begin
         cd_event_o <= cd_event_w;                        // RULE20
         if (cd_event_w) begin
            win_cnt <= 3'(CD_WINDOW_CYC);                 // RULE18
         end else if (win_cnt != 3'h0) begin
            win_cnt <= win_cnt - 3'h1;
         end
      end
   end

   // Trigger, pause and timebase selection
   always_comb begin
      if (ctrl.trig_src < SRC_CHANGE) begin
         trig_lvl = pfi_s[ctrl.trig_src[2:0]];
      end else if (ctrl.trig_src == SRC_CHANGE) begin
         trig_lvl = cd_event_o;                           // RULE20
      end else if (ctrl.trig_src == SRC_NEIGHBOR) begin
         trig_lvl = input_start_trigger_i;
      end else begin
         trig_lvl = 1'b0;
      end
      if (ctrl.pause_src < SRC_CHANGE) begin
         pause_lvl = pfi_s[ctrl.pause_src[2:0]];
      end else begin
         pause_lvl = input_pause_trigger_i;
      end
      case (ctrl.tb_sel)                                  // RULE1
         TB_100MHZ: tb_tick = tick_100mhz_i;
         TB_20MHZ:  tb_tick = tick_20mhz_i;
         TB_100KHZ: tb_tick = tick_100khz_i;
         default:   tb_tick = ext_edge;
      endcase
   end

   assign ext_edge  = edge_hit(pfi_s[ctrl.tb_line], ext_prev, 1'b0);
   assign trig_hit  = edge_hit(trig_lvl, trig_prev, ctrl.trig_fall);      // RULE6
   assign pause_act = ctrl.pause_en & (pause_lvl ^ ctrl.pause_low);      // RULE12
   assign onboard   = (ctrl.tb_sel != TB_EXT) & (ctrl.sclk_src == SCLK_ENGINE);
   assign div_end   = tb_tick & (div_cnt + 32'h1 >= divisor);            // RULE1

   // Raw sample tick from the chosen sample clock source
   always_comb begin
      case (ctrl.sclk_src)
         SCLK_ENGINE: raw_tick = div_end;
         SCLK_CHANGE: raw_tick = cd_event_o;              // RULE19
         SCLK_EXT:    raw_tick = ext_edge;
         default:     raw_tick = 1'b0;
      endcase
   end

   // Pause is looked at only on a sample boundary
   assign emit     = (state == DTCD_RUN) & (raw_tick | pend) & ~pause_act;   // RULE8 RULE9
   assign last_smp = (count != 32'h0) & (smp_cnt + 32'h1 == count);         // RULE23
   assign start_go = (state == DTCD_ARMED) & (~ctrl.trig_en | trig_hit);     // RULE3 RULE5

   // Timing engine state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= DTCD_IDLE;
         div_cnt <= 32'h0;
         dly_cnt <= 32'h0;
         smp_cnt <= 32'h0;
      end else if (ce_i) begin
         if (wr_ctrl & wr_ctrl_v[1]) begin
            state <= DTCD_IDLE;
         end else begin
            case (state)
               DTCD_IDLE: begin
                  if (wr_ctrl & wr_ctrl_v[0]) begin
                     state <= DTCD_ARMED;
                  end
               end
               DTCD_ARMED: begin
                  if (start_go) begin
                     state   <= DTCD_DELAY;
                     dly_cnt <= 32'h0;
                     smp_cnt <= 32'h0;
                  end
               end
               DTCD_DELAY: begin
                  if (delay == 32'h0 || (tb_tick && dly_cnt + 32'h1 >= delay)) begin
                     state   <= DTCD_RUN;                 // RULE22
                     div_cnt <= 32'h0;
                  end else if (tb_tick) begin
                     dly_cnt <= dly_cnt + 32'h1;          // RULE22
                  end
               end
               DTCD_RUN: begin
                  if (tb_tick) begin
                     div_cnt <= div_end ? 32'h0 : div_cnt + 32'h1;
                  end
                  if (emit) begin
                     smp_cnt <= smp_cnt + 32'h1;
                     if (last_smp) begin
                        state <= ctrl.retrig ? DTCD_ARMED : DTCD_IDLE;   // RULE4 RULE5
                     end
                  end
               end
               default: state <= DTCD_IDLE;
            endcase
         end
      end
   end

   // Held sample: first after delay with the engine source, or onboard under pause
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend <= 1'b0;
      end else if (ce_i) begin
         if (state == DTCD_DELAY) begin
            pend <= (ctrl.sclk_src == SCLK_ENGINE);       // RULE22
         end else if (state != DTCD_RUN || emit) begin
            pend <= 1'b0;
         end else if (raw_tick & pause_act) begin
            pend <= onboard;                              // RULE10 RULE11
         end else if (pause_act & ~onboard) begin
            pend <= 1'b0;                                 // RULE11
         end
      end
   end

   // Sample clock, start pulse and underflow
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         output_sample_clock_o  <= 1'b0;
         output_start_trigger_o <= 1'b0;
         underflow              <= 1'b0;
      end else if (ce_i) begin
         output_sample_clock_o <= emit;
         output_start_trigger_o <= start_go;              // RULE7
         if (emit & out_buf_empty_i) begin
            underflow <= 1'b1;                            // RULE21
         end else if (wr_fire && wb_adr_i == OFF_STATUS && wb_sel_i[0] && wb_dat_i[ST_UNDERFLOW]) begin
            underflow <= 1'b0;
         end
      end
   end

   // Change seen flag, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cd_irq_o <= 1'b0;
      end else if (ce_i) begin
         if (cd_event_w) begin
            cd_irq_o <= 1'b1;                             // RULE19
         end else if (wr_fire && wb_adr_i == OFF_STATUS && wb_sel_i[0] && wb_dat_i[ST_CD_SEEN]) begin
            cd_irq_o <= 1'b0;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl    <= RST_CTRL;
         divisor <= RST_DIVISOR;
         delay   <= RST_DELAY;
         count   <= RST_COUNT;
         cd_rise <= '0;
         cd_fall <= '0;
         pu_dir  <= 16'h0000;
         pu_val  <= 16'h0000;
         route   <= 18'h00000;
      end else if (ce_i && wr_fire) begin
         case (wb_adr_i)
            OFF_CTRL:    ctrl    <= dtcd_ctrl_t'({wr_ctrl_v[31:2], 2'b00});   // RULE24
            OFF_DIVISOR: divisor <= lane_merge(divisor, wb_dat_i, wb_sel_i);
            OFF_DELAY:   delay   <= lane_merge(delay, wb_dat_i, wb_sel_i);
            OFF_COUNT:   count   <= lane_merge(count, wb_dat_i, wb_sel_i);
            OFF_CD_RISE: cd_rise <= NUM_CD'(lane_merge(32'(cd_rise), wb_dat_i, wb_sel_i));
            OFF_CD_FALL: cd_fall <= NUM_CD'(lane_merge(32'(cd_fall), wb_dat_i, wb_sel_i));
            OFF_PU_DIR:  pu_dir  <= 16'(lane_merge(32'(pu_dir), wb_dat_i, wb_sel_i));
            OFF_PU_VAL:  pu_val  <= 16'(lane_merge(32'(pu_val), wb_dat_i, wb_sel_i));
            OFF_ROUTE:   route   <= 18'(lane_merge(32'(route), wb_dat_i, wb_sel_i));
            default:     ;
         endcase
      end
   end

   // Line drivers; timebase is never an export choice
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dio_o     <= '0;                                 // RULE13
         dio_oe_o  <= '0;                                 // RULE13
         pfi_o     <= '0;
         pfi_oe_o  <= '0;                                 // RULE13
         star_o    <= 1'b0;
         star_oe_o <= 1'b0;
      end else if (ce_i) begin
         dio_o    <= pu_val;                              // RULE14
         dio_oe_o <= pu_dir;                              // RULE14
         for (int i = 0; i < NUM_PFI; i++) begin
            pfi_oe_o[i] <= (route[2*i +: 2] != RT_INPUT);
            case (route[2*i +: 2])                        // RULE2
               RT_SCLK:   pfi_o[i] <= ~emit;
               RT_START:  pfi_o[i] <= start_go;           // RULE7
               RT_CHANGE: pfi_o[i] <= cd_event_w;         // RULE19
               default:   pfi_o[i] <= 1'b0;
            endcase
         end
         star_oe_o <= (route[ROUTE_STAR_LSB +: 2] != RT_INPUT);
         case (route[ROUTE_STAR_LSB +: 2])                // RULE2
            RT_SCLK:   star_o <= ~emit;
            RT_START:  star_o <= start_go;                // RULE7
            RT_CHANGE: star_o <= cd_event_w;              // RULE19
            default:   star_o <= 1'b0;
         endcase
      end
   end

   // Read data mux; unmapped offsets read zero
   always_comb begin
      case (wb_adr_i)
         OFF_CTRL:    rd_v = ctrl;
         OFF_DIVISOR: rd_v = divisor;
         OFF_DELAY:   rd_v = delay;
         OFF_COUNT:   rd_v = count;
         OFF_STATUS:  rd_v = {27'h0, cd_irq_o, underflow, pause_act,
                              state == DTCD_ARMED, state == DTCD_DELAY || state == DTCD_RUN};
         OFF_CD_RISE: rd_v = 32'(cd_rise);
         OFF_CD_FALL: rd_v = 32'(cd_fall);
         OFF_PU_DIR:  rd_v = 32'(pu_dir);
         OFF_PU_VAL:  rd_v = 32'(pu_val);
         OFF_ROUTE:   rd_v = 32'(route);
         default:     rd_v = 32'h0000_0000;
      endcase
   end

   // Wishbone answer one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req & ~wb_ack_o & ~wb_we_i) begin
            wb_dat_o <= rd_v;
         end
      end
   end

endmodule : dtcd_core

// File: dtcd_pkg.sv
// Purpose: Shared constants and types for the digital I/O timing and change-detect block
// Assumes: 32-bit classic Wishbone register access, 50 MHz system clock
// Notes:   Register byte offsets, field positions, reset values and timing counts
package dtcd_pkg;

   // Line counts
   localparam int NUM_DIO = 16;
   localparam int NUM_PFI = 8;
   localparam int NUM_CD  = NUM_DIO + NUM_PFI;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_DIVISOR = 8'h04;
   localparam logic [7:0] OFF_DELAY   = 8'h08;
   localparam logic [7:0] OFF_COUNT   = 8'h0c;
   localparam logic [7:0] OFF_STATUS  = 8'h10;
   localparam logic [7:0] OFF_CD_RISE = 8'h14;
   localparam logic [7:0] OFF_CD_FALL = 8'h18;
   localparam logic [7:0] OFF_PU_DIR  = 8'h1c;
   localparam logic [7:0] OFF_PU_VAL  = 8'h20;
   localparam logic [7:0] OFF_ROUTE   = 8'h24;

   // Status field positions
   localparam int ST_BUSY      = 0;
   localparam int ST_ARMED     = 1;
   localparam int ST_PAUSED    = 2;
   localparam int ST_UNDERFLOW = 3;
   localparam int ST_CD_SEEN   = 4;

   // Route field position of the star trigger line (pfi lines use bits 15:0)
   localparam int ROUTE_STAR_LSB = 16;

   // Reset values
   localparam logic [31:0] RST_DIVISOR = 32'h0000_0001;
   localparam logic [31:0] RST_DELAY   = 32'h0000_0002;
   localparam logic [31:0] RST_COUNT   = 32'h0000_0000;

   // Timing: change merge window, longest time rounds down
   localparam int CLK_PERIOD_NS = 20;
   localparam int CD_WINDOW_NS  = 50;
   localparam int CD_WINDOW_CYC = (CD_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 : (CD_WINDOW_NS / CLK_PERIOD_NS);

   // Timebase selections
   localparam logic [1:0] TB_100MHZ = 2'h0;
   localparam logic [1:0] TB_20MHZ  = 2'h1;
   localparam logic [1:0] TB_100KHZ = 2'h2;
   localparam logic [1:0] TB_EXT    = 2'h3;

   // Sample clock sources
   localparam logic [1:0] SCLK_ENGINE = 2'h0;
   localparam logic [1:0] SCLK_CHANGE = 2'h1;
   localparam logic [1:0] SCLK_EXT    = 2'h2;

   // Trigger / pause source codes above the pfi lines
   localparam logic [3:0] SRC_CHANGE   = 4'h8;
   localparam logic [3:0] SRC_NEIGHBOR = 4'h9;

   // Line route codes
   localparam logic [1:0] RT_INPUT  = 2'h0;
   localparam logic [1:0] RT_SCLK   = 2'h1;
   localparam logic [1:0] RT_START  = 2'h2;
   localparam logic [1:0] RT_CHANGE = 2'h3;

   // Control register layout
   typedef struct packed {
      logic [9:0] rsvd;
      logic [1:0] sclk_src;
      logic [2:0] tb_line;
      logic [3:0] pause_src;
      logic [3:0] trig_src;
      logic [1:0] tb_sel;
      logic       pause_low;
      logic       pause_en;
      logic       trig_fall;
      logic       trig_en;
      logic       retrig;
      logic       stop;
      logic       arm;
   } dtcd_ctrl_t;

   localparam dtcd_ctrl_t RST_CTRL = '0;

   // Timing engine states
   typedef enum logic [1:0] {
      DTCD_IDLE,
      DTCD_ARMED,
      DTCD_DELAY,
      DTCD_RUN
   } dtcd_state_t;

endpackage : dtcd_pkg

// File: dtcd_core_assertions.sv
// Purpose: Port assertions for dtcd_core
// Assumes: ce_i held high by the bench
// Notes:   Bound into every dtcd_core instance
`timescale 1ns/100ps
module dtcd_core_assertions
   import dtcd_pkg::*;
(
   input wire logic               clk_i,                  // Clock
   input wire logic               rst_i,                  // Reset
   input wire logic               ce_i,                   // Enable
   input wire logic               wb_cyc_i,               // Cycle
   input wire logic               wb_stb_i,               // Strobe
   input wire logic               wb_ack_o,               // Ack
   input wire logic [NUM_DIO-1:0] dio_oe_o,               // Dio enables
   input wire logic [NUM_PFI-1:0] pfi_oe_o,               // Pfi enables
   input wire logic               star_oe_o,              // Star enable
   input wire logic               output_start_trigger_o, // Start pulse
   input wire logic               output_sample_clock_o,  // Sample pulse
   input wire logic               cd_event_o,             // Change event
   input wire logic               cd_irq_o                // Change flag
);
   default clocking cb @(posedge clk_i); endclocking
   AST_ACK_RESP: assert property (disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("ack missing");
   AST_ACK_ONE: assert property (disable iff (rst_i) wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
   AST_ACK_IDLE: assert property (disable iff (rst_i) !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
   AST_RST_LINES: assert property (rst_i |=> dio_oe_o == '0 && pfi_oe_o == '0 && !star_oe_o)
      else $error("line driven in reset");
   AST_RST_OUTS: assert property (rst_i |=> !output_sample_clock_o && !cd_event_o && !cd_irq_o)
      else $error("output set in reset");
   AST_START_PULSE: assert property (disable iff (rst_i) output_start_trigger_o |=> !output_start_trigger_o)
      else $error("start pulse too long");
   AST_CD_MERGE: assert property (disable iff (rst_i) cd_event_o |=> !cd_event_o [*2])
      else $error("events inside window");
   AST_CD_FLAG: assert property (disable iff (rst_i) $rose(cd_event_o) |-> ##[0:1] cd_irq_o)
      else $error("change flag not set");
endmodule : dtcd_core_assertions
bind dtcd_core dtcd_core_assertions chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dio_oe_o(dio_oe_o), .pfi_oe_o(pfi_oe_o), .star_oe_o(star_oe_o),
   .output_start_trigger_o(output_start_trigger_o), .output_sample_clock_o(output_sample_clock_o),
   .cd_event_o(cd_event_o), .cd_irq_o(cd_irq_o));

// File: dtcd_partner.sv
// Purpose: Far-side timebase tick source
// Assumes: 50 MHz system clock
// Notes:   Mid ticks come two in every five cycles
`timescale 1ns/100ps
module dtcd_partner #(
   parameter int DIV_100K = 500 // Cycles per slow tick
) (
   input  wire logic clk_i,         // Clock
   input  wire logic rst_i,         // Reset
   output logic      tick_100mhz_o, // Fast tick
   output logic      tick_20mhz_o,  // Mid tick
   output logic      tick_100khz_o  // Slow tick
);
   int cnt5;
   int cnt_slow;
   // Tick phase counters
   always_ff @(posedge clk_i) begin
      cnt5 <= (rst_i || cnt5 == 4) ? 0 : cnt5 + 1;
      cnt_slow <= (rst_i || cnt_slow == DIV_100K - 1) ? 0 : cnt_slow + 1;
   end
   // Strobes, silent in reset
   assign tick_100mhz_o = !rst_i;
   assign tick_20mhz_o = !rst_i && (cnt5 == 0 || cnt5 == 2);
   assign tick_100khz_o = !rst_i && cnt_slow == 0;
endmodule : dtcd_partner

// File: tb_dio_timing_and_change_detect.sv
// Purpose: Self-checking bench for dtcd_core
// Assumes: ce_i high, neighbour triggers idle
// Notes:   Register rows first, then hand tests
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("unexpected %0t bad value", $time); end end
module tb_dio_timing_and_change_detect
   import dtcd_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} dtcd_row_t;
   localparam dtcd_row_t ROWS [10] = '{'{OFF_CTRL, 1'h0, 32'h0, RST_CTRL}, '{OFF_DIVISOR, 1'h0, 32'h0, RST_DIVISOR},
      '{OFF_DELAY, 1'h0, 32'h0, RST_DELAY}, '{OFF_COUNT, 1'h1, 32'h4, 32'h4}, '{8'h3c, 1'h1, 32'hffffffff, 32'h0},
      '{OFF_CD_RISE, 1'h1, 32'hffffffff, 32'hffffff}, '{OFF_CD_FALL, 1'h1, 32'h2, 32'h2},
      '{OFF_PU_DIR, 1'h1, 32'hf, 32'hf}, '{OFF_PU_VAL, 1'h1, 32'h5, 32'h5}, '{OFF_STATUS, 1'h0, 32'h0, 32'h0}};
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h0;
   logic [31:0] dat = 32'h0, rdat, rd;
   logic [NUM_DIO-1:0] dio = '0, dout, doe;
   logic [NUM_PFI-1:0] programmable_function_line = '0, pfi_oe;
   logic t100m, t20m, t100k, ack, smp, st, cd, irq, star_oe;
   int num_errors = 0, checks_done = 0, cycles = 0, nsmp = 0, nst = 0, ncd = 0;
   dtcd_core dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .tick_100mhz_i(t100m),
      .tick_20mhz_i(t20m), .tick_100khz_i(t100k), .input_start_trigger_i(1'b0), .input_pause_trigger_i(1'b0),
      .out_buf_empty_i(1'b1), .dio_i(dio), .dio_o(dout), .dio_oe_o(doe), .pfi_i(programmable_function_line), .pfi_o(), .pfi_oe_o(pfi_oe),
      .star_o(), .star_oe_o(star_oe), .output_sample_clock_o(smp), .output_start_trigger_o(st),
      .cd_event_o(cd), .cd_irq_o(irq));
   dtcd_partner tbase (.clk_i(clk_i), .rst_i(rst_i), .tick_100mhz_o(t100m), .tick_20mhz_o(t20m),
      .tick_100khz_o(t100k));
   // Clock and pulse counters with hang guard
   always #10 clk_i = !clk_i;
   always @(posedge clk_i) begin
      nsmp += (smp === 1'b1);
      nst += (st === 1'b1);
      ncd += (cd === 1'b1);
      if (++cycles == 3000) begin
         num_errors++;
         end_sim;
      end
   end
   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // One classic cycle, held until ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      {cyc, stb} <= 2'h0;
   endtask : bus
   task automatic clr;
      @(negedge clk_i);
      {nsmp, nst, ncd} = '0;
   endtask : clr
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
   endtask : w
   // Main sequence
   initial begin
      w(10);
      rst_i <= 1'b0;
      w(1);
      `CHK({doe, pfi_oe, star_oe}, 25'h0)
      foreach (ROWS[i]) begin
         if (ROWS[i].w) bus(1'b1, ROWS[i].a, ROWS[i].d);
         bus(1'b0, ROWS[i].a, 32'h0);
         `CHK(rd, ROWS[i].e)
      end
      `CHK({doe, doe & dout}, 32'h000f_0005)
      clr;
      @(posedge clk_i) dio[0] <= 1'b1;
      @(posedge clk_i) dio[1] <= 1'b1;
      w(8);
      `CHK(ncd, 1)
      `CHK(irq, 1'b1)
      clr;
      @(posedge clk_i) dio[0] <= 1'b0;
      w(8);
      `CHK(ncd, 0)
      @(posedge clk_i) dio[1] <= 1'b0;
      w(8);
      `CHK(ncd, 1)
      // Software start, paused by pfi 1 high
      @(posedge clk_i) programmable_function_line[1] <= 1'b1;
      clr;
      bus(1'b1, OFF_CTRL, 32'h0000_2021);
      w(30);
      `CHK(nsmp, 0)
      @(posedge clk_i) programmable_function_line[1] <= 1'b0;
      w(30);
      `CHK(nsmp, 4)
      `CHK(nst, 1)
      bus(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd[ST_UNDERFLOW], 1'b1)
      bus(1'b1, OFF_STATUS, 32'h8);
      bus(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd[ST_UNDERFLOW], 1'b0)
      // Retriggerable bursts on pfi 0, second pulse lands mid-burst
      clr;
      bus(1'b1, OFF_CTRL, 32'h0000_000d);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_i) programmable_function_line[0] <= 1'b1;
         w(2);
         @(posedge clk_i) programmable_function_line[0] <= 1'b0;
         w(k == 0 ? 1 : 30);
      end
      `CHK(nsmp, 8)
      `CHK(nst, 2)
      bus(1'b1, OFF_CTRL, 32'h0000_0002);
      // Falling edge start only
      clr;
      bus(1'b1, OFF_CTRL, 32'h0000_0019);
      @(posedge clk_i) programmable_function_line[0] <= 1'b1;
      w(20);
      `CHK(nst, 0)
      @(posedge clk_i) programmable_function_line[0] <= 1'b0;
      w(20);
      `CHK(nst, 1)
      end_sim;
   end
endmodule : tb_dio_timing_and_change_detect
